//--- common/ptm_pkg.sv
// Package: register map, field positions, reset values and modes of the periodic timer
package ptm_pkg;
    // Register offsets on the plain register port
    localparam logic [2:0] PTM_ADDR_CTRL = 3'h0;
    localparam logic [2:0] PTM_ADDR_COMPARE_A_VALUE = 3'h1;
    localparam logic [2:0] PTM_ADDR_COMPARE_P_VALUE = 3'h2;
    localparam logic [2:0] PTM_ADDR_CNT = 3'h3;
    localparam logic [2:0] PTM_ADDR_FLAG = 3'h4;
    localparam logic [2:0] PTM_ADDR_CLKDIV = 3'h5;
    // Control register field positions
    localparam int PTM_CTRL_RUN = 0;
    localparam int PTM_CTRL_IO_LO = 1;
    localparam int PTM_CTRL_IO_HI = 2;
    localparam int PTM_CTRL_M_LO = 3;
    localparam int PTM_CTRL_M_HI = 4;
    localparam int PTM_CTRL_CCLR = 5;
    localparam int PTM_CTRL_OC = 6;
    localparam int PTM_CTRL_POL = 7;
    localparam int PTM_CTRL_CKS = 8;
    localparam int PTM_CTRL_EXTCK = 9;
    // Flag register field positions
    localparam int PTM_FLAG_A = 0;
    localparam int PTM_FLAG_P = 1;
    // Reset values
    localparam logic [9:0] PTM_CTRL_RST = 10'h000;
    localparam logic [9:0] PTM_CMP_RST = 10'h000;
    localparam logic [2:0] PTM_DIV_RST = 3'h0;
    // Mode select field values
    localparam logic [1:0] PTM_MODE_CMP = 2'h0;
    localparam logic [1:0] PTM_MODE_CAP = 2'h1;
    localparam logic [1:0] PTM_MODE_PWM = 2'h2;
    localparam logic [1:0] PTM_MODE_TMR = 2'h3;
    // Pin action field values
    localparam logic [1:0] PTM_IO_RISE = 2'h0;
    localparam logic [1:0] PTM_IO_FALL = 2'h1;
    localparam logic [1:0] PTM_IO_BOTH = 2'h2;
    localparam logic [1:0] PTM_IO_NONE = 2'h3;
    localparam logic [1:0] PTM_IO_LOW = 2'h0;
    localparam logic [1:0] PTM_IO_HIGH = 2'h1;
    localparam logic [1:0] PTM_IO_PWM = 2'h2;
    localparam logic [1:0] PTM_IO_PULSE = 2'h3;
    // Capture flag delay after the latch, in ticks; unused, the core sets the flag in the latch cycle
    localparam int PTM_CAP_FLAG_TICKS = 1;
endpackage

//--- core/ptm_pin_sync.sv
// Three-stage pin synchroniser with agreed-edge detection
`timescale 1ns/1ps
`default_nettype none
module ptm_pin_sync
(
    input wire logic mclk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable
    input wire logic pin, // Asynchronous pin
    output logic level, // Filtered level
    output logic rise, // One-cycle rising pulse
    output logic fall // One-cycle falling pulse
);
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ptm_sync_t;
    ptm_sync_t st_q;
    ptm_sync_t st_d;

    // Stage one feeds only stage two; the level moves when stages two and three agree
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3)
        begin
            st_d.lvl = st_q.s3;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    assign level = st_q.lvl;
    assign rise = (st_q.s2 == st_q.s3) && st_q.s3 && !st_q.lvl;
    assign fall = (st_q.s2 == st_q.s3) && !st_q.s3 && st_q.lvl;
endmodule
`default_nettype wire

//--- core/ptm_core.sv
// Periodic timer: PWM, single-pulse and capture modes behind a plain register port
// How it works
// - PWM period 1024 when P zero, else P
// - Duty from A; A at least P gives 100%
// - PWM keeps running though pin forced
// - PWM ignores clear select, clears on P
// - Run rise starts counter, drives leading edge
// - External clock pin edge sets run bit
// - Run clear or A match ends pulse
// - A match ending pulse raises interrupt
// - Pulse counter cleared only on run rise
// - Mode 01 captures from selected pin
// - Capture counter free runs while run high
// - Capture edge copies counter into A, interrupts
// - Capture P match clears counter, interrupts
// - Capture with P zero counts full range
// - Pin action picks edge; 11 no capture
// - Capture ignores clear, level, polarity bits
// - Pulses under two ticks may be lost
// - Latch within one tick, flag with latch
// - PWM sets separate A and P flags
// - Initial level and polarity shape PWM
`timescale 1ns/1ps
`default_nettype none
module ptm_core
#(
    parameter int CNT_W = 10 // Counter width
)
(
    input wire logic mclk, // System clock, 25 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state when low
    input wire logic [2:0] addr, // Register address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [15:0] rdata, // Read data, valid the cycle after rd
    input wire logic ext_clock_pin, // External clock / trigger pin
    input wire logic capture_pin, // Capture input pin
    output logic tm_out, // Timer output pin
    output logic tm_out_oe, // Output enable, high while driving
    output logic irq // Timer interrupt request, high while a flag is set
);
    import ptm_pkg::*;

    typedef struct packed
    {
        logic [9:0] ctrl;
        logic [CNT_W-1:0] cmp_a;
        logic [CNT_W-1:0] cmp_p;
        logic [CNT_W-1:0] cnt;
        logic flag_a;
        logic flag_p;
        logic [2:0] div_sel;
        logic [6:0] pre;
        logic run_prev;
        logic cap_pend;
        logic pwm;
        logic pulse;
        logic out;
        logic oe;
        logic irq;
        logic [15:0] rdata;
    } ptm_state_t;
    ptm_state_t st_q;
    ptm_state_t st_d;

    logic ext_lvl;
    logic ext_rise;
    logic ext_fall;
    logic cap_lvl;
    logic cap_rise;
    logic cap_fall;

    // Pins come from outside the clock domain
    ptm_pin_sync u_sync_ext
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(ext_clock_pin),
        .level(ext_lvl),
        .rise(ext_rise),
        .fall(ext_fall)
    );
    ptm_pin_sync u_sync_cap
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .pin(capture_pin),
        .level(cap_lvl),
        .rise(cap_rise),
        .fall(cap_fall)
    );

    logic [1:0] mode;
    logic [1:0] io;
    logic run;
    logic tick;
    logic [7:0] div_mask;
    logic sel_rise;
    logic sel_fall;
    logic cap_edge;
    logic trig_edge;
    logic [CNT_W-1:0] cnt_max;
    logic match_a;
    logic match_p;
    logic run_rise;
    logic wave;

    assign mode = {st_q.ctrl[PTM_CTRL_M_HI], st_q.ctrl[PTM_CTRL_M_LO]};
    assign io = {st_q.ctrl[PTM_CTRL_IO_HI], st_q.ctrl[PTM_CTRL_IO_LO]};
    assign run = st_q.ctrl[PTM_CTRL_RUN];
    assign run_rise = run && !st_q.run_prev;
    assign cnt_max = '1;

    // Timer tick: fsys divided by a power of two, or external pin rising edge
    always_comb
    begin
        div_mask = 8'((9'h001 << st_q.div_sel) - 9'h001);
        if (st_q.ctrl[PTM_CTRL_EXTCK])
        begin
            tick = ext_rise;
        end
        else
        begin
            tick = ((8'({1'b0, st_q.pre}) & div_mask) == div_mask);
        end
    end

    // Capture source and edge choice; 11 selects no edge at all
    always_comb
    begin
        sel_rise = st_q.ctrl[PTM_CTRL_CKS] ? ext_rise : cap_rise;
        sel_fall = st_q.ctrl[PTM_CTRL_CKS] ? ext_fall : cap_fall;
        case (io)
            PTM_IO_RISE: cap_edge = sel_rise;
            PTM_IO_FALL: cap_edge = sel_fall;
            PTM_IO_BOTH: cap_edge = sel_rise | sel_fall;
            default: cap_edge = 1'b0;
        endcase
    end

    // External pin active edge for the single-pulse trigger
    assign trig_edge = ext_rise;

    // Comparators: P of zero means a full 1024-count period
    assign match_p = tick && run && (st_q.cmp_p == '0 ? st_q.cnt == cnt_max
                                                      : st_q.cnt == st_q.cmp_p - 1'b1);
    assign match_a = tick && run && (st_q.cnt == st_q.cmp_a - 1'b1) && (st_q.cmp_a != '0);

    // PWM high phase: A at or above the period is held high all period
    assign wave = (st_q.cmp_p != '0 && st_q.cmp_a >= st_q.cmp_p) ||
                  (st_q.cnt < st_q.cmp_a);

    // Next state
    always_comb
    begin
        st_d = st_q;
        st_d.run_prev = run;
        st_d.pre = st_q.pre + 7'h01;
        st_d.rdata = '0;

        // Register writes; hardware events below take precedence over them
        if (wr)
        begin
            case (addr)
                PTM_ADDR_CTRL: st_d.ctrl = wdata[9:0];
                PTM_ADDR_COMPARE_A_VALUE: st_d.cmp_a = wdata[CNT_W-1:0];
                PTM_ADDR_COMPARE_P_VALUE: st_d.cmp_p = wdata[CNT_W-1:0];
                PTM_ADDR_CLKDIV: st_d.div_sel = wdata[2:0];
                PTM_ADDR_FLAG:
                begin
                    // Write one to clear
                    if (wdata[PTM_FLAG_A])
                    begin
                        st_d.flag_a = 1'b0;
                    end
                    if (wdata[PTM_FLAG_P])
                    begin
                        st_d.flag_p = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Reads return a word the next cycle; unmapped reads give zero
        if (rd)
        begin
            case (addr)
                PTM_ADDR_CTRL: st_d.rdata = {6'h00, st_q.ctrl};
                PTM_ADDR_COMPARE_A_VALUE: st_d.rdata = 16'(st_q.cmp_a);
                PTM_ADDR_COMPARE_P_VALUE: st_d.rdata = 16'(st_q.cmp_p);
                PTM_ADDR_CNT: st_d.rdata = 16'(st_q.cnt);
                PTM_ADDR_FLAG: st_d.rdata = {14'h0000, st_q.flag_p, st_q.flag_a};
                PTM_ADDR_CLKDIV: st_d.rdata = {13'h0000, st_q.div_sel};
                default: st_d.rdata = '0;
            endcase
        end

        case (mode)
            PTM_MODE_PWM:
            begin
                if (io == PTM_IO_PULSE)
                begin
                    // Single pulse; a pin edge sets the run bit
                    if (trig_edge && !run)
                    begin
                        st_d.ctrl[PTM_CTRL_RUN] = 1'b1;
                    end
                    if (run_rise)
                    begin
                        st_d.cnt = '0;
                        st_d.pulse = 1'b1;
                    end
                    else if (!run)
                    begin
                        st_d.pulse = 1'b0;
                    end
                    else if (match_a)
                    begin
                        st_d.ctrl[PTM_CTRL_RUN] = 1'b0;
                        st_d.pulse = 1'b0;
                        st_d.flag_a = 1'b1;
                    end
                    else if (tick)
                    begin
                        st_d.cnt = st_q.cnt + 1'b1;
                    end
                end
                else
                begin
                    // PWM runs whatever the pin action; clear select is not looked at
                    if (run_rise)
                    begin
                        st_d.cnt = '0;
                    end
                    else if (match_p)
                    begin
                        st_d.cnt = '0;
                        st_d.flag_p = 1'b1;
                    end
                    else if (run && tick)
                    begin
                        st_d.cnt = st_q.cnt + 1'b1;
                    end
                    if (match_a)
                    begin
                        st_d.flag_a = 1'b1;
                    end
                    st_d.pwm = run && wave;
                end
            end
            PTM_MODE_CAP:
            begin
                // Free running count; P bounds it; clear, level and polarity ignored
                if (run_rise)
                begin
                    st_d.cnt = '0;
                end
                else if (match_p)
                begin
                    st_d.cnt = '0;
                    st_d.flag_p = 1'b1;
                end
                else if (run && tick)
                begin
                    st_d.cnt = st_q.cnt + 1'b1;
                end
                // Edge held until next tick: latch and flag together within one tick
                if (cap_edge && run)
                begin
                    st_d.cap_pend = 1'b1;
                end
                if (st_q.cap_pend && tick)
                begin
                    st_d.cmp_a = st_q.cnt;
                    st_d.flag_a = 1'b1;
                    st_d.cap_pend = cap_edge && run;
                end
            end
            default:
            begin
                // Compare and timer/counter modes are outside this block: counter idles
                st_d.cnt = '0;
            end
        endcase
        if (mode != PTM_MODE_CAP || !run)
        begin
            st_d.cap_pend = 1'b0;
        end

        // Output pin drive; capture mode has no output function
        st_d.oe = (mode == PTM_MODE_PWM);
        if (mode == PTM_MODE_PWM && io == PTM_IO_PULSE)
        begin
            st_d.out = st_d.pulse ^ st_q.ctrl[PTM_CTRL_POL];
        end
        else if (mode == PTM_MODE_PWM)
        begin
            case (io)
                PTM_IO_LOW: st_d.out = 1'b0 ^ st_q.ctrl[PTM_CTRL_POL];
                PTM_IO_HIGH: st_d.out = 1'b1 ^ st_q.ctrl[PTM_CTRL_POL];
                default: st_d.out = (st_d.pwm ~^ st_q.ctrl[PTM_CTRL_OC]) ^
                                    st_q.ctrl[PTM_CTRL_POL];
            endcase
        end
        else
        begin
            st_d.out = 1'b0;
        end
        st_d.irq = st_d.flag_a | st_d.flag_p;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
            st_q.ctrl <= PTM_CTRL_RST;
            st_q.cmp_a <= PTM_CMP_RST;
            st_q.cmp_p <= PTM_CMP_RST;
            st_q.div_sel <= PTM_DIV_RST;
        end
        else if (ce)
        begin
            st_q <= st_d;
        end
    end

    assign rdata = st_q.rdata;
    assign tm_out = st_q.out;
    assign tm_out_oe = st_q.oe;
    assign irq = st_q.irq;
endmodule
`default_nettype wire

//--- bench/ptm_core_asserts.sv
// Checker: port-level properties of the periodic timer core
`timescale 1ns/1ps
`default_nettype none
module ptm_core_asserts
import ptm_pkg::*;
#(
    parameter int CNT_W = 10 // Counter width
)
(
    input wire logic mclk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic ce, // Clock enable
    input wire logic [2:0] addr, // Address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    input wire logic [15:0] rdata, // Read data
    input wire logic ext_clock_pin, // Trigger pin
    input wire logic capture_pin, // Capture pin
    input wire logic tm_out, // Output pin
    input wire logic tm_out_oe, // Output enable
    input wire logic irq // Interrupt
);
    logic [9:0] ctl_q, a_q, p_q;
    logic [10:0] age_q;
    logic pwm, pol, setl;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Shadow of software writes; age lets a change settle before judging
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctl_q <= 10'h000;
            a_q <= 10'h000;
            p_q <= 10'h000;
            age_q <= 11'h000;
        end
        else if (wr && addr <= PTM_ADDR_COMPARE_P_VALUE)
        begin
            age_q <= 11'h000;
            if (addr == PTM_ADDR_CTRL) ctl_q <= wdata[9:0];
            if (addr == PTM_ADDR_COMPARE_A_VALUE) a_q <= wdata[9:0];
            if (addr == PTM_ADDR_COMPARE_P_VALUE) p_q <= wdata[9:0];
        end
        else if (age_q != 11'h7ff)
            age_q <= age_q + 11'h001;
    end
    // Run is only trusted outside pulse mode, where hardware never moves it
    assign pwm = ctl_q[4:3] == PTM_MODE_PWM && ctl_q[0] && ctl_q[2:1] != PTM_IO_PULSE;
    assign pol = ctl_q[PTM_CTRL_POL];
    assign setl = age_q >= 11'h004;
    sequence s_arm;
        wr && addr == PTM_ADDR_CTRL && wdata[7:0] == 8'h57 && !ctl_q[0] && a_q >= 10'h008;
    endsequence
    sequence s_lead;
        ##[1:4] tm_out;
    endsequence
    a_rdata_idle:
    assert property (!$past(rd) |-> rdata == 16'h0000) else $error("rdata outside slot");
    a_rdata_width:
    assert property ($past(rd) |-> rdata[15:10] == 6'h00) else $error("rdata upper bits");
    a_period_bound:
    assert property ($past(rd) && $past(addr) == PTM_ADDR_CNT && pwm && age_q == 11'h7ff
        && p_q != 10'h000 |-> rdata[9:0] < p_q) else $error("count passed period");
    a_duty_full:
    assert property (pwm && setl && ctl_q[2:1] == PTM_IO_PWM && ctl_q[PTM_CTRL_OC]
        && p_q != 10'h000 && a_q >= p_q |-> tm_out == !pol) else $error("duty not full");
    a_duty_zero:
    assert property (pwm && setl && ctl_q[2:1] == PTM_IO_PWM && ctl_q[PTM_CTRL_OC]
        && a_q == 10'h000 |-> tm_out == pol) else $error("duty not empty");
    a_pin_forced:
    assert property (pwm && setl && !ctl_q[2] && !pol |-> tm_out == ctl_q[1])
        else $error("forced level wrong");
    a_oe_idle:
    assert property (setl && ctl_q[4:3] != PTM_MODE_PWM |-> !tm_out_oe)
        else $error("pin driven outside mode 10");
    a_oe_pwm:
    assert property (pwm && setl |-> tm_out_oe) else $error("pin not driven");
    a_pulse_lead:
    assert property (s_arm |-> s_lead) else $error("no pulse leading edge");
endmodule
`default_nettype wire

//--- bench/ptm_pin_env.sv
// Partner: pin sources and output load of the periodic timer
`timescale 1ns/1ps
`default_nettype none
module ptm_pin_env
(
    input wire logic mclk, // Clock
    input wire logic tm_out, // Pin value
    input wire logic tm_out_oe, // Pin enable
    output logic ext_clock_pin, // Trigger or capture source
    output logic capture_pin, // Capture source
    output logic pin_level // Level at the load
);
    // Pull-down load: a released pin reads low, never a stale value
    assign pin_level = tm_out_oe ? tm_out : 1'b0;
    initial
    begin
        ext_clock_pin = 1'b0;
        capture_pin = 1'b0;
    end
    // Each level is held far over two ticks so no edge is lost
    task automatic drive(input logic sel, input logic lvl);
        @(posedge mclk);
        if (sel) ext_clock_pin <= lvl;
        else capture_pin <= lvl;
        repeat (8) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Testbench: register-level scenarios for the periodic timer core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ptm_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ce = 1'b1;
    logic [15:0] rdata, v, c;
    logic [15:0] hi = 16'h0000;
    logic ext_clock_pin, capture_pin, tm_out, tm_out_oe, irq, pin_level;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    ptm_core #(.CNT_W(10)) uut
    (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin),
        .tm_out(tm_out), .tm_out_oe(tm_out_oe), .irq(irq)
    );
    ptm_pin_env u_env
    (
        .mclk(mclk), .tm_out(tm_out), .tm_out_oe(tm_out_oe), .ext_clock_pin(ext_clock_pin),
        .capture_pin(capture_pin), .pin_level(pin_level)
    );
    always #20 mclk = ~mclk;
    // High time is summed on the falling edge so reads at the rising edge never race
    always @(negedge mclk) hi <= hi + {15'h0000, pin_level};
    // Cut a hang short; the tests need a few thousand cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Set compare values and control, settle, then count high cycles in a window
    task automatic pwm(input logic [9:0] a, p, input logic [15:0] ctl, input int s, n,
        input logic [15:0] e);
        logic [15:0] b;
        wr_reg(PTM_ADDR_COMPARE_A_VALUE, {6'h00, a});
        wr_reg(PTM_ADDR_COMPARE_P_VALUE, {6'h00, p});
        wr_reg(PTM_ADDR_CTRL, ctl);
        repeat (s) @(posedge mclk);
        b = hi;
        repeat (n) @(posedge mclk);
        chk(hi - b, e);
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            rd_reg(i[2:0], v);
            chk(v, 16'h0000);
        end
        // PWM duty over two periods, one period when P is zero, flags, polarity, clear select, forced levels
        pwm(4, 10, 16'h0055, 4, 20, 16'd8);
        wr_reg(PTM_ADDR_FLAG, 16'h0003);
        repeat (20) @(posedge mclk);
        rd_reg(PTM_ADDR_FLAG, v);
        chk(v, 16'h0003);
        chk({15'h0000, irq}, 16'h0001);
        pwm(4, 10, 16'h00d5, 4, 20, 16'd12);
        pwm(4, 10, 16'h0075, 4, 20, 16'd8);
        pwm(4, 10, 16'h0051, 4, 20, 16'd0);
        pwm(4, 10, 16'h0053, 4, 20, 16'd20);
        rd_reg(PTM_ADDR_CNT, v);
        rd_reg(PTM_ADDR_CNT, c);
        chk({15'h0000, v !== c}, 16'h0001);
        pwm(12, 10, 16'h0055, 4, 20, 16'd20);
        pwm(0, 10, 16'h0055, 4, 20, 16'd0);
        repeat (2050) @(posedge mclk);
        rd_reg(PTM_ADDR_CNT, v);
        chk({15'h0000, v < 16'h000a}, 16'h0001);
        pwm(512, 0, 16'h0055, 4, 1024, 16'd512);
        // Enable low for 20 edges: only the 3 enabled edges around it may count
        rd_reg(PTM_ADDR_CNT, v);
        @(posedge mclk);
        ce <= 1'b0;
        repeat (20) @(posedge mclk);
        ce <= 1'b1;
        rd_reg(PTM_ADDR_CNT, c);
        chk((c - v) & 16'h03ff, 16'h0003);
        // Single pulse from software, then from the pin, then ended early
        wr_reg(PTM_ADDR_CTRL, 16'h0000);
        wr_reg(PTM_ADDR_FLAG, 16'h0003);
        pwm(8, 10, 16'h0056, 0, 4, 16'd0);
        pwm(8, 10, 16'h0057, 0, 30, 16'd8);
        rd_reg(PTM_ADDR_CTRL, v);
        chk(v, 16'h0056);
        rd_reg(PTM_ADDR_FLAG, v);
        chk(v, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        v = hi;
        u_env.drive(1'b1, 1'b1);
        u_env.drive(1'b1, 1'b0);
        chk(hi - v, 16'd8);
        wr_reg(PTM_ADDR_COMPARE_A_VALUE, 16'h0014);
        wr_reg(PTM_ADDR_CTRL, 16'h0057);
        repeat (3) @(posedge mclk);
        pwm(20, 10, 16'h0056, 2, 25, 16'd0);
        // Capture on each edge code from the capture pin; timer clock stays internal
        for (int e = 0; e < 4; e++)
        begin
            wr_reg(PTM_ADDR_CTRL, 16'h0008 | 16'(e * 2));
            wr_reg(PTM_ADDR_CTRL, 16'h0009 | 16'(e * 2));
            for (int l = 1; l >= 0; l--)
            begin
                wr_reg(PTM_ADDR_FLAG, 16'h0003);
                u_env.drive(1'b0, l[0]);
                rd_reg(PTM_ADDR_FLAG, v);
                chk(v & 16'h0001, 16'(e == 2 || e == 1 - l));
            end
        end
        // P of zero lets the count run the full range, so no wrap lies between the reads
        wr_reg(PTM_ADDR_COMPARE_P_VALUE, 16'h0000);
        wr_reg(PTM_ADDR_CTRL, 16'h0009);
        rd_reg(PTM_ADDR_CNT, v);
        u_env.drive(1'b0, 1'b1);
        rd_reg(PTM_ADDR_COMPARE_A_VALUE, c);
        chk({15'h0000, c >= v && c <= v + 16'h000c}, 16'h0001);
        wr_reg(PTM_ADDR_FLAG, 16'h0003);
        wr_reg(PTM_ADDR_CTRL, 16'h0109);
        u_env.drive(1'b1, 1'b1);
        rd_reg(PTM_ADDR_FLAG, v);
        chk(v & 16'h0001, 16'h0001);
        wr_reg(PTM_ADDR_CTRL, 16'h0000);
        wr_reg(PTM_ADDR_FLAG, 16'h0003);
        pwm(0, 20, 16'h00e9, 4, 50, 16'd0);
        rd_reg(PTM_ADDR_FLAG, v);
        chk(v & 16'h0002, 16'h0002);
        rd_reg(PTM_ADDR_CNT, v);
        chk({15'h0000, v < 16'h0014}, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        end_sim();
    end
endmodule
bind ptm_core ptm_core_asserts #(.CNT_W(CNT_W)) u_chk
(
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_clock_pin(ext_clock_pin), .capture_pin(capture_pin),
    .tm_out(tm_out), .tm_out_oe(tm_out_oe), .irq(irq)
);
`default_nettype wire
